// ---- common/mdsp_pkg.sv ----
package mdsp_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses on the plain register port)
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0C;
  localparam logic [7:0] ADDR_CMD = 8'h10;

  // Control register fields.
  localparam int CTRL_STN_LSB = 0;
  localparam int CTRL_BAUD_LSB = 4;
  localparam int CTRL_PAR_LSB = 8;
  localparam int CTRL_CARD_BIT = 10;
  localparam logic [3:0] STN_RESET = 4'h0;
  localparam logic [2:0] BAUD_RESET = 3'h5;
  localparam logic [1:0] PAR_RESET = 2'h0;

  // Status register bits.
  localparam int STAT_ONLINE_BIT = 0;
  localparam int STAT_RXVALID_BIT = 1;
  localparam int STAT_TXBUSY_BIT = 2;
  localparam int STAT_OVERRUN_BIT = 3;
  localparam int STAT_REPLY_BIT = 4;

  // Transmit data register: bit 8 marks the last character of a reply.
  localparam int TXDATA_LAST_BIT = 8;

  // Command register bits, each acts once per write.
  localparam int CMD_RELEASE_BIT = 0;
  localparam int CMD_STEP_BAUD_BIT = 1;
  localparam int CMD_STEP_PAR_BIT = 2;
  localparam int CMD_CLR_OVR_BIT = 3;

  // ------------------------------------------------------------------
  // Character format and line timing
  // ------------------------------------------------------------------
  localparam int CHAR_BITS = 7;
  localparam logic [3:0] TX_BITS_AFTER_START = 4'h9;
  localparam logic [2:0] RX_PARITY_SLOT = 3'h7;
  localparam logic [6:0] ASCII_CR = 7'h0D;
  localparam logic [6:0] ASCII_ZERO = 7'h30;
  localparam logic [3:0] STN_TENS = 4'hA;
  localparam int BAUD_COUNT = 6;
  localparam logic [2:0] BAUD_LAST = 3'h5;
  localparam int unsigned BAUD_RATE [0:5] = '{300, 600, 1200, 2400, 4800, 9600};
  localparam int CNT_W = 18;
  localparam int unsigned CLK_HZ_DEFAULT = 50000000;

  typedef enum logic [1:0] {
    PAR_EVEN = 2'b00,
    PAR_ODD = 2'b01,
    PAR_MARK = 2'b10,
    PAR_SPACE = 2'b11
  } parity_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_e;

endpackage

// ---- rtl/pin_sync3.sv ----
// ------------------------------------------------------------------
// Three-stage input synchroniser with agreement filter
// ------------------------------------------------------------------
module pin_sync3 #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic pin_i,
  output logic level_o
);

  logic meta_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  // The first stage feeds only the second; the level follows once stages two and three agree.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      meta_ff <= IDLE_LEVEL;
      s2_ff <= IDLE_LEVEL;
      s3_ff <= IDLE_LEVEL;
      level_ff <= IDLE_LEVEL;
    end else if (ce_i) begin
      meta_ff <= pin_i;
      s2_ff <= meta_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end

  assign level_o = level_ff;

endmodule

// ---- rtl/bit_timer.sv ----
// ------------------------------------------------------------------
// Bit interval timer: pulses after a first interval, then each period
// ------------------------------------------------------------------
module bit_timer #(
  parameter int W = 18
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic [W-1:0] first_i,
  input wire logic [W-1:0] period_i,
  output logic tick_o
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic expire;

  // The counter is preloaded while stopped so the first tick lands after first_i cycles.
  assign expire = run_i && (cnt_ff <= W'(1));
  assign nxt_cnt = !run_i ? first_i : (expire ? period_i : cnt_ff - W'(1));
  assign tick_o = expire;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cnt_ff <= '0;
    end else if (ce_i) begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// ---- rtl/multidrop_serial_port.sv ----
// How it works
// - start, seven data, parity, stop: ten bits.
// - station number register holds zero through fifteen.
// - nonzero station stays silent until number received.
// - carriage return ends session after reply sent.
// - station zero is always on line.
// - six baud rates, stepping wraps to first.
// - even or odd parity counts the ones.
// - mark sends one, space sends zero.
// - received parity bit is ignored entirely.
// - only the serial card choice takes effect.
module multidrop_serial_port #(
  parameter int unsigned CLK_HZ = mdsp_pkg::CLK_HZ_DEFAULT
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic rxd_i,
  output logic txd_o,
  output logic txd_oe_n_o
);

  localparam int W = mdsp_pkg::CNT_W;

  // ------------------------------------------------------------------
  // Bit period table
  // ------------------------------------------------------------------

  // Cycles per bit for each selectable rate, derived from the clock rate.
  logic [W-1:0] bit_cyc [0:mdsp_pkg::BAUD_COUNT-1];

  for (genvar gi = 0; gi < mdsp_pkg::BAUD_COUNT; gi++) begin : g_rate
    assign bit_cyc[gi] = W'(CLK_HZ / mdsp_pkg::BAUD_RATE[gi]);
  end

  // ------------------------------------------------------------------
  // State declarations
  // ------------------------------------------------------------------
  logic [3:0] stn_ff;
  logic [2:0] baud_sel_ff;
  logic [1:0] par_mode_ff;
  logic online_ff;
  logic reply_pend_ff;
  logic release_req_ff;
  logic rx_valid_ff;
  logic overrun_ff;
  logic [6:0] rx_char_ff;
  logic [6:0] rx_hold_ff;
  logic [6:0] prev_char_ff;
  logic [2:0] rx_cnt_ff;
  mdsp_pkg::rx_state_e rx_state_ff;
  mdsp_pkg::rx_state_e nxt_rx_state;
  logic tx_busy_ff;
  logic tx_line_ff;
  logic [8:0] tx_sr_ff;
  logic [3:0] tx_left_ff;
  logic [31:0] rdata_ff;

  // ------------------------------------------------------------------
  // Register port decode
  // ------------------------------------------------------------------
  logic wr_ctrl;
  logic wr_tx;
  logic wr_cmd;
  logic rd_rx;
  logic [2:0] wr_baud;
  logic [2:0] baud_step;
  logic [1:0] par_step;

  assign wr_ctrl = wr_i && (addr_i == mdsp_pkg::ADDR_CTRL);
  assign wr_tx = wr_i && (addr_i == mdsp_pkg::ADDR_TXDATA);
  assign wr_cmd = wr_i && (addr_i == mdsp_pkg::ADDR_CMD);
  assign rd_rx = rd_i && (addr_i == mdsp_pkg::ADDR_RXDATA);

  // A written rate index past the last rate lands on the first one.
  assign wr_baud = wdata_i[mdsp_pkg::CTRL_BAUD_LSB +: 3];
  assign baud_step = (baud_sel_ff == mdsp_pkg::BAUD_LAST) ? 3'h0 : baud_sel_ff + 3'h1;
  assign par_step = par_mode_ff + 2'h1;

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------

  // Station, rate and parity; the card field is not stored since only serial exists.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      stn_ff <= mdsp_pkg::STN_RESET;
      baud_sel_ff <= mdsp_pkg::BAUD_RESET;
      par_mode_ff <= mdsp_pkg::PAR_RESET;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        stn_ff <= wdata_i[mdsp_pkg::CTRL_STN_LSB +: 4];
        baud_sel_ff <= (wr_baud > mdsp_pkg::BAUD_LAST) ? 3'h0 : wr_baud;
        par_mode_ff <= wdata_i[mdsp_pkg::CTRL_PAR_LSB +: 2];
      end else if (wr_cmd) begin
        if (wdata_i[mdsp_pkg::CMD_STEP_BAUD_BIT]) begin
          baud_sel_ff <= baud_step;
        end
        if (wdata_i[mdsp_pkg::CMD_STEP_PAR_BIT]) begin
          par_mode_ff <= par_step;
        end
      end
    end
  end

  logic [W-1:0] bit_period;
  logic [W-1:0] half_period;

  assign bit_period = bit_cyc[baud_sel_ff];
  assign half_period = bit_period >> 1;

  // ------------------------------------------------------------------
  // Receive path
  // ------------------------------------------------------------------
  logic rx_level;
  logic rx_tick;
  logic rx_done;

  pin_sync3 #(
    .IDLE_LEVEL(1'b1)
  ) u_rx_sync (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .pin_i(rxd_i),
    .level_o(rx_level)
  );

  bit_timer #(
    .W(W)
  ) u_rx_timer (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .run_i(rx_state_ff != mdsp_pkg::RX_IDLE),
    .first_i(half_period),
    .period_i(bit_period),
    .tick_o(rx_tick)
  );

  // Frame walker: mid-start check, seven data, a parity slot, then stop.
  always_comb begin
    nxt_rx_state = rx_state_ff;
    case (rx_state_ff)
      mdsp_pkg::RX_IDLE: begin
        if (!rx_level) begin
          nxt_rx_state = mdsp_pkg::RX_START;
        end
      end
      mdsp_pkg::RX_START: begin
        if (rx_tick) begin
          nxt_rx_state = rx_level ? mdsp_pkg::RX_IDLE : mdsp_pkg::RX_DATA;
        end
      end
      mdsp_pkg::RX_DATA: begin
        if (rx_tick && (rx_cnt_ff == mdsp_pkg::RX_PARITY_SLOT)) begin
          nxt_rx_state = mdsp_pkg::RX_STOP;
        end
      end
      mdsp_pkg::RX_STOP: begin
        if (rx_tick) begin
          nxt_rx_state = mdsp_pkg::RX_IDLE;
        end
      end
      default: begin
        nxt_rx_state = mdsp_pkg::RX_IDLE;
      end
    endcase
  end

  // A character is complete when the stop slot reads high; a low stop drops it.
  assign rx_done = (rx_state_ff == mdsp_pkg::RX_STOP) && rx_tick && rx_level;

  // Data bits arrive least significant first; the parity slot is sampled into nothing.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rx_state_ff <= mdsp_pkg::RX_IDLE;
      rx_cnt_ff <= 3'h0;
      rx_char_ff <= 7'h00;
    end else if (ce_i) begin
      rx_state_ff <= nxt_rx_state;
      if (rx_state_ff != mdsp_pkg::RX_DATA) begin
        rx_cnt_ff <= 3'h0;
      end else if (rx_tick) begin
        rx_cnt_ff <= rx_cnt_ff + 3'h1;
        if (rx_cnt_ff != mdsp_pkg::RX_PARITY_SLOT) begin
          rx_char_ff <= {rx_level, rx_char_ff[6:1]};
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Station addressing
  // ------------------------------------------------------------------
  logic stn_zero;
  logic online;
  logic [6:0] tens_char;
  logic [6:0] units_char;
  logic stn_match;
  logic got_cr;

  // Station zero counts as on line at all times.
  assign stn_zero = (stn_ff == 4'h0);
  assign online = stn_zero || online_ff;

  // The station number is recognised as two ASCII digits, tens then units.
  assign tens_char = (stn_ff >= mdsp_pkg::STN_TENS) ? mdsp_pkg::ASCII_ZERO + 7'h01
                                                     : mdsp_pkg::ASCII_ZERO;
  assign units_char = mdsp_pkg::ASCII_ZERO + {3'h0, (stn_ff >= mdsp_pkg::STN_TENS)
                                               ? stn_ff - mdsp_pkg::STN_TENS : stn_ff};
  assign stn_match = (prev_char_ff == tens_char) && (rx_char_ff == units_char);
  assign got_cr = rx_char_ff == mdsp_pkg::ASCII_CR;

  // ------------------------------------------------------------------
  // Transmit path
  // ------------------------------------------------------------------
  logic tx_tick;
  logic tx_accept;
  logic tx_parity;
  logic [6:0] tx_char;
  logic go_offline;

  bit_timer #(
    .W(W)
  ) u_tx_timer (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .run_i(tx_busy_ff),
    .first_i(bit_period),
    .period_i(bit_period),
    .tick_o(tx_tick)
  );

  // A character is sent only while on line, idle, and not after the reply was closed.
  assign tx_accept = wr_tx && online && !tx_busy_ff && !release_req_ff;
  assign tx_char = wdata_i[6:0];

  // Parity bit per mode.
  always_comb begin
    case (mdsp_pkg::parity_e'(par_mode_ff))
      mdsp_pkg::PAR_EVEN: tx_parity = ^tx_char;
      mdsp_pkg::PAR_ODD: tx_parity = ~^tx_char;
      mdsp_pkg::PAR_MARK: tx_parity = 1'b1;
      mdsp_pkg::PAR_SPACE: tx_parity = 1'b0;
      default: tx_parity = 1'b0;
    endcase
  end

  // The start bit goes out at once; each tick shifts the next bit, stop last.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      tx_busy_ff <= 1'b0;
      tx_line_ff <= 1'b1;
      tx_sr_ff <= 9'h1FF;
      tx_left_ff <= 4'h0;
    end else if (ce_i) begin
      if (tx_accept) begin
        tx_busy_ff <= 1'b1;
        tx_line_ff <= 1'b0;
        tx_sr_ff <= {1'b1, tx_parity, tx_char};
        tx_left_ff <= mdsp_pkg::TX_BITS_AFTER_START;
      end else if (tx_busy_ff && tx_tick) begin
        if (tx_left_ff == 4'h0) begin
          tx_busy_ff <= 1'b0;
          tx_line_ff <= 1'b1;
        end else begin
          tx_line_ff <= tx_sr_ff[0];
          tx_sr_ff <= {1'b1, tx_sr_ff[8:1]};
          tx_left_ff <= tx_left_ff - 4'h1;
        end
      end
    end
  end

  // The shared line is driven only during a character.
  assign txd_o = tx_line_ff;
  assign txd_oe_n_o = !tx_busy_ff;

  // ------------------------------------------------------------------
  // Session control
  // ------------------------------------------------------------------
  logic release_now;

  // After a carriage return, the session closes once the reply is marked done and sent.
  assign release_now = (wr_tx && tx_accept && wdata_i[mdsp_pkg::TXDATA_LAST_BIT])
                       || (wr_cmd && wdata_i[mdsp_pkg::CMD_RELEASE_BIT]);
  assign go_offline = release_req_ff && !tx_busy_ff;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      online_ff <= 1'b0;
      reply_pend_ff <= 1'b0;
      release_req_ff <= 1'b0;
      prev_char_ff <= 7'h00;
    end else if (ce_i) begin
      if (rx_done) begin
        prev_char_ff <= rx_char_ff;
      end
      if (stn_zero) begin
        online_ff <= 1'b0;
        reply_pend_ff <= 1'b0;
        release_req_ff <= 1'b0;
      end else if (go_offline) begin
        online_ff <= 1'b0;
        reply_pend_ff <= 1'b0;
        release_req_ff <= 1'b0;
      end else begin
        if (rx_done && !online_ff && stn_match) begin
          online_ff <= 1'b1;
        end
        if (rx_done && online_ff && got_cr) begin
          reply_pend_ff <= 1'b1;
        end
        if (release_now && (reply_pend_ff || (rx_done && online_ff && got_cr))) begin
          release_req_ff <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Receive holding register
  // ------------------------------------------------------------------
  logic rx_deliver;

  // Only characters heard while on line reach software; a new one beats a read clear.
  assign rx_deliver = rx_done && online;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rx_valid_ff <= 1'b0;
      overrun_ff <= 1'b0;
      rx_hold_ff <= 7'h00;
    end else if (ce_i) begin
      if (rx_deliver) begin
        rx_hold_ff <= rx_char_ff;
        rx_valid_ff <= 1'b1;
      end else if (rd_rx) begin
        rx_valid_ff <= 1'b0;
      end
      if (rx_deliver && rx_valid_ff && !rd_rx) begin
        overrun_ff <= 1'b1;
      end else if (wr_cmd && wdata_i[mdsp_pkg::CMD_CLR_OVR_BIT]) begin
        overrun_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  // The card field always reads as serial; a parallel request has no effect.
  assign ctrl_word = {21'h0, 1'b1, par_mode_ff, 1'b0, baud_sel_ff, stn_ff};
  assign status_word = {27'h0, reply_pend_ff, overrun_ff, tx_busy_ff, rx_valid_ff, online};
  assign rd_mux = (addr_i == mdsp_pkg::ADDR_CTRL) ? ctrl_word :
                  (addr_i == mdsp_pkg::ADDR_STATUS) ? status_word :
                  (addr_i == mdsp_pkg::ADDR_RXDATA) ? {25'h0, rx_hold_ff} : 32'h0;

  // Read data stands for exactly the cycle after the strobe.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_ff <= 32'h0;
    end else if (ce_i) begin
      rdata_ff <= rd_i ? rd_mux : 32'h0;
    end
  end

  assign rdata_o = rdata_ff;

endmodule

// ---- verif/multidrop_serial_port_checker.sv ----
// ------------------------------------------------------------------
// Port checker for the multi-drop serial port
// ------------------------------------------------------------------
module multidrop_serial_port_checker #(
  parameter int unsigned CLK_HZ = mdsp_pkg::CLK_HZ_DEFAULT
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic rxd_i,
  input wire logic txd_o,
  input wire logic txd_oe_n_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  logic [2:0] baud_ff;
  logic [3:0] stn_ff;
  logic [15:0] low_cnt_ff;
  logic [2:0] nxt_baud;
  logic [15:0] nxt_low_cnt;
  logic [31:0] frame_cyc;

  // Shadow of the rate index and station, so frame length can be judged.
  wire ctrl_wr = wr_i && addr_i == mdsp_pkg::ADDR_CTRL;
  wire step_wr = wr_i && addr_i == mdsp_pkg::ADDR_CMD && wdata_i[1];
  wire [2:0] wr_baud = (wdata_i[6:4] > 3'h5) ? 3'h0 : wdata_i[6:4];
  wire [2:0] step_baud = (baud_ff == 3'h5) ? 3'h0 : baud_ff + 3'h1;
  assign nxt_baud = ctrl_wr ? wr_baud : (step_wr ? step_baud : baud_ff);
  assign nxt_low_cnt = txd_oe_n_o ? 16'h0 : low_cnt_ff + 16'h1;
  assign frame_cyc = 10 * (CLK_HZ / mdsp_pkg::BAUD_RATE[baud_ff]);

  // Helper registers follow writes and count driven cycles.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      baud_ff <= 3'h5;
      stn_ff <= 4'h0;
      low_cnt_ff <= 16'h0;
    end else if (ce_i) begin
      baud_ff <= nxt_baud;
      stn_ff <= ctrl_wr ? wdata_i[3:0] : stn_ff;
      low_cnt_ff <= nxt_low_cnt;
    end
  end

  sequence s_start;
    $fell(txd_oe_n_o);
  endsequence
  sequence s_ctrl_read;
    $past(rd_i) && $past(addr_i) == mdsp_pkg::ADDR_CTRL;
  endsequence

  property p_idle_high;
    txd_oe_n_o |-> txd_o;
  endproperty
  property p_rdata_idle;
    !$past(rd_i) |-> rdata_o == 32'h0000_0000;
  endproperty
  property p_start_low;
    s_start |-> !txd_o [*8];
  endproperty
  property p_frame_len;
    $rose(txd_oe_n_o) |-> {16'h0, low_cnt_ff} == frame_cyc;
  endproperty
  property p_stop_high;
    $rose(txd_oe_n_o) |-> $past(txd_o);
  endproperty
  property p_card_serial;
    s_ctrl_read |-> rdata_o[mdsp_pkg::CTRL_CARD_BIT];
  endproperty
  property p_baud_track;
    s_ctrl_read |-> rdata_o[6:4] == baud_ff;
  endproperty
  property p_online_zero;
    $past(rd_i) && $past(addr_i) == mdsp_pkg::ADDR_STATUS && stn_ff == 4'h0
      |-> rdata_o[mdsp_pkg::STAT_ONLINE_BIT];
  endproperty

  a_idle_high: assert property (p_idle_high) else $error("line low while idle");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  a_start_low: assert property (p_start_low) else $error("start bit short");
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
  a_stop_high: assert property (p_stop_high) else $error("stop bit low");
  a_card_serial: assert property (p_card_serial) else $error("card not serial");
  a_baud_track: assert property (p_baud_track) else $error("rate index wrong");
  a_online_zero: assert property (p_online_zero) else $error("station zero off line");
endmodule

bind multidrop_serial_port multidrop_serial_port_checker #(.CLK_HZ(CLK_HZ)) chk_i (
  .ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i),
  .ce_i(ce_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .rxd_i(rxd_i),
  .txd_o(txd_o),
  .txd_oe_n_o(txd_oe_n_o)
);

// ---- verif/serial_terminal_model.sv ----
// ------------------------------------------------------------------
// Master terminal on the shared line
// ------------------------------------------------------------------
module serial_terminal_model (
  input wire logic ref_clk_i,
  input wire logic [15:0] bit_cyc_i,
  input wire logic line_i,
  output logic rxd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] got_frame;
  int frame_cnt;

  initial begin
    rxd_o = 1'b1;
    frame_cnt = 0;
    got_frame = 10'h000;
  end

  // Sends start, seven data bits first bit lowest, parity, then stop.
  task automatic send_char(input logic [6:0] ch, input logic par);
    logic [9:0] bits;
    bits = {1'b1, par, ch, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_o <= bits[i];
      repeat (bit_cyc_i) @(posedge ref_clk_i);
    end
  endtask

  // Captures each frame at mid bit; the pulled-up line idles high.
  always begin
    @(negedge line_i);
    repeat (bit_cyc_i / 2) @(posedge ref_clk_i);
    for (int i = 0; i < 10; i++) begin
      #1 got_frame[i] = line_i;
      if (i < 9) repeat (bit_cyc_i) @(posedge ref_clk_i);
    end
    frame_cnt++;
  end
endmodule

// ---- verif/multidrop_serial_port_tb.sv ----
// ------------------------------------------------------------------
// Self-checking bench for the multi-drop serial port
// ------------------------------------------------------------------
module multidrop_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CLK_HZ = 96000;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ce_w = 1'b1;
  logic [31:0] rdata_o;
  logic rxd_w;
  logic txd_o;
  logic txd_oe_n_o;
  logic line_w;
  logic [15:0] bit_cyc = 16'h000A;
  int err_total = 0;
  int check_count = 0;

  always #10 ref_clk_i = ~ref_clk_i;
  // Pull-up holds the shared line high while the port is not driving.
  assign line_w = txd_oe_n_o ? 1'b1 : txd_o;

  multidrop_serial_port #(.CLK_HZ(CLK_HZ)) DUT (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .ce_i(ce_w), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .rxd_i(rxd_w), .txd_o(txd_o), .txd_oe_n_o(txd_oe_n_o));
  serial_terminal_model term (.ref_clk_i(ref_clk_i), .bit_cyc_i(bit_cyc), .line_i(line_w),
    .rxd_o(rxd_w));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    reg_rd(a, v);
    chk(v & m, e);
  endtask
  // Polls the busy flag until the transmitter has gone idle.
  task automatic wait_idle();
    logic [31:0] v;
    v = 32'h4;
    for (int n = 0; n < 2000 && v[2] !== 1'b0; n++) reg_rd(mdsp_pkg::ADDR_STATUS, v);
    chk({31'h0, v[2]}, 32'h0);
  endtask
  // Sends one character and compares the frame seen on the line.
  task automatic tx_check(input logic [8:0] d, input logic par);
    int f;
    f = term.frame_cnt;
    reg_wr(mdsp_pkg::ADDR_TXDATA, {23'h0, d});
    wait_idle();
    chk(32'(term.frame_cnt - f), 32'h1);
    chk({22'h0, term.got_frame}, {22'h0, 1'b1, par, d[6:0], 1'b0});
  endtask
  task automatic rx_send(input logic [6:0] c, input logic par);
    term.send_char(c, par);
    repeat (5) @(posedge ref_clk_i);
  endtask

  task automatic t_reset();
    rd_chk(mdsp_pkg::ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0450);
    rd_chk(mdsp_pkg::ADDR_STATUS, 32'h1F, 32'h01);
    reg_wr(8'h14, 32'hFFFF_FFFF);
    rd_chk(8'h14, 32'hFFFF_FFFF, 32'h0);
    reg_wr(mdsp_pkg::ADDR_CTRL, 32'h0000_0050);
    rd_chk(mdsp_pkg::ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0450);
  endtask
  task automatic t_parity();
    logic [6:0] c;
    logic p;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 2; k++) begin
        c = k ? 7'h07 : 7'h35;
        p = (m == 0) ? ^c : (m == 1) ? ~^c : (m == 2);
        tx_check({2'b00, c}, p);
      end
      reg_wr(mdsp_pkg::ADDR_CMD, 32'h4);
    end
    rd_chk(mdsp_pkg::ADDR_CTRL, 32'h300, 32'h0);
  endtask
  task automatic t_baud();
    reg_wr(mdsp_pkg::ADDR_CMD, 32'h2);
    rd_chk(mdsp_pkg::ADDR_CTRL, 32'h70, 32'h0);
    bit_cyc = 16'(CLK_HZ / 300);
    tx_check(9'h055, ^7'h55);
    reg_wr(mdsp_pkg::ADDR_CTRL, 32'h0000_0070);
    rd_chk(mdsp_pkg::ADDR_CTRL, 32'h70, 32'h0);
    reg_wr(mdsp_pkg::ADDR_CTRL, 32'h0000_0050);
    bit_cyc = 16'(CLK_HZ / 9600);
    rd_chk(mdsp_pkg::ADDR_CTRL, 32'h70, 32'h50);
  endtask
  // A rate step written while the clock enable is low must leave the rate alone.
  task automatic t_freeze();
    @(posedge ref_clk_i);
    ce_w <= 1'b0;
    reg_wr(mdsp_pkg::ADDR_CMD, 32'h2);
    ce_w <= 1'b1;
    rd_chk(mdsp_pkg::ADDR_CTRL, 32'h70, 32'h50);
  endtask
  task automatic t_rx();
    for (int p = 0; p < 2; p++) begin
      rx_send(7'h41, p[0]);
      rd_chk(mdsp_pkg::ADDR_STATUS, 32'h2, 32'h2);
      rd_chk(mdsp_pkg::ADDR_RXDATA, 32'h7F, 32'h41);
      rd_chk(mdsp_pkg::ADDR_STATUS, 32'h2, 32'h0);
    end
  endtask
  task automatic t_station(input logic [3:0] stn);
    logic [6:0] t;
    logic [6:0] u;
    t = mdsp_pkg::ASCII_ZERO + {3'h0, stn / 4'hA};
    u = mdsp_pkg::ASCII_ZERO + {3'h0, stn % 4'hA};
    reg_wr(mdsp_pkg::ADDR_CTRL, 32'h50 | {28'h0, stn});
    rd_chk(mdsp_pkg::ADDR_CTRL, 32'hF, {28'h0, stn});
    rd_chk(mdsp_pkg::ADDR_STATUS, 32'h1, 32'h0);
    reg_wr(mdsp_pkg::ADDR_TXDATA, 32'h41);
    rd_chk(mdsp_pkg::ADDR_STATUS, 32'h4, 32'h0);
    rx_send(t, ^t);
    rx_send(u, ^u);
    rd_chk(mdsp_pkg::ADDR_STATUS, 32'h1, 32'h1);
    rx_send(mdsp_pkg::ASCII_CR, ^mdsp_pkg::ASCII_CR);
    rd_chk(mdsp_pkg::ADDR_STATUS, 32'h11, 32'h11);
    tx_check(9'h14B, ^7'h4B);
    rd_chk(mdsp_pkg::ADDR_STATUS, 32'h1, 32'h0);
  endtask
  task automatic t_zero();
    reg_wr(mdsp_pkg::ADDR_CTRL, 32'h0000_0050);
    rd_chk(mdsp_pkg::ADDR_STATUS, 32'h1, 32'h1);
    rx_send(mdsp_pkg::ASCII_CR, ^mdsp_pkg::ASCII_CR);
    rd_chk(mdsp_pkg::ADDR_STATUS, 32'h1, 32'h1);
    rd_chk(mdsp_pkg::ADDR_STATUS, 32'hA, 32'hA);
    reg_wr(mdsp_pkg::ADDR_CMD, 32'h8);
    rd_chk(mdsp_pkg::ADDR_STATUS, 32'h8, 32'h0);
  endtask

  task automatic close_out();
    $display("Mismatches %0d of %0d checks", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (20) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    t_reset();
    t_parity();
    t_baud();
    t_freeze();
    t_rx();
    t_station(4'hC);
    t_station(4'hF);
    t_zero();
    close_out();
  end

  // Watchdog: the whole run needs well under this many cycles.
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    err_total++;
    close_out();
  end
endmodule
